// [inc/tx_clock_reset_pkg.sv]
/*
  Constants, field widths and state encodings shared by the transmitter
  clock and reset block and its per-lane section.
  Assumes a single 100 MHz core clock that is also the link clock.
*/
package tx_clock_reset_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_LANES = 4;
  localparam int CHAR_W    = 8;
  localparam int MODE_W    = 2;
  localparam int SYNC_W    = 2;

  // ----------------------------------------------------------------
  // Clocking figures
  // ----------------------------------------------------------------
  localparam int LINK_CLK_PERIOD_NS = 10;
  localparam int LANE_RATE_DIVISOR  = 40;
  localparam int DIRECT_CLK_DIVISOR = 2;

  // ----------------------------------------------------------------
  // Coding sublayer modes
  // ----------------------------------------------------------------
  localparam logic [MODE_W-1:0] MODE_HARD_CODING = 2'h0;
  localparam logic [MODE_W-1:0] MODE_SOFT_CODING = 2'h1;
  localparam logic [MODE_W-1:0] MODE_DIRECT      = 2'h2;

  // ----------------------------------------------------------------
  // Characters and reset values
  // ----------------------------------------------------------------
  localparam logic [CHAR_W-1:0] K_COMMA_CHAR = 8'hbc;
  localparam logic [CHAR_W-1:0] IDLE_CHAR    = 8'h00;
  localparam logic [SYNC_W-1:0] SYNC_RESET   = 2'h0;
  localparam logic [SYNC_W-1:0] SYNC_HELD    = 2'h3;

  // ----------------------------------------------------------------
  // Link state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LINK_HELD  = 2'b00,
    LINK_COMMA = 2'b01,
    LINK_RUN   = 2'b10
  } link_state_t;

endpackage

// [inc/lane_ctrl_if.sv]
/*
  Carrier between the link controller and one lane section.
  Assumes both ends run on core_clk.
*/
interface lane_ctrl_if;
  import tx_clock_reset_pkg::*;

  logic              coding_rst;
  logic              serializer_rst;
  logic              link_active;
  logic              link_run;
  logic              direct_mode;
  logic [CHAR_W-1:0] user_char;
  logic              par_clk_strobe;
  logic              par_clk;
  logic [CHAR_W-1:0] tx_char;
  logic              tx_is_k;
  logic              serializer_on;
  logic              coding_rst_stat;
  logic              serializer_rst_stat;

  modport ctrl (
    output coding_rst, serializer_rst, link_active, link_run, direct_mode, user_char,
    input  par_clk_strobe, par_clk, tx_char, tx_is_k, serializer_on,
           coding_rst_stat, serializer_rst_stat
  );

  modport lane (
    input  coding_rst, serializer_rst, link_active, link_run, direct_mode, user_char,
    output par_clk_strobe, par_clk, tx_char, tx_is_k, serializer_on,
           coding_rst_stat, serializer_rst_stat
  );
endinterface

// [rtl/tx_lane_section.sv]
/*
  One lane: coding sublayer and analog serializer section reset handling,
  parallel clock strobe and character source.
  Assumes the resets on the carrier are already synchronised to core_clk.
*/
module tx_lane_section
  import tx_clock_reset_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic reset,
  lane_ctrl_if.lane lane
);

  logic phase;

  // ----------------------------------------------------------------
  // Parallel clock
  // ----------------------------------------------------------------
  // parallel clock rate
  always_ff @(posedge core_clk)
  begin
    if (reset || lane.coding_rst)
    begin
      phase               <= 1'b0;
      lane.par_clk_strobe <= 1'b0;
      lane.par_clk        <= 1'b0;
    end
    else
    begin
      phase               <= lane.direct_mode ? ~phase : 1'b0;
      lane.par_clk_strobe <= lane.direct_mode ? ~phase : 1'b1;
      lane.par_clk        <= lane.direct_mode ? ~phase : ~lane.par_clk;
    end
  end

  // ----------------------------------------------------------------
  // Character source
  // ----------------------------------------------------------------
  // coding section held
  always_ff @(posedge core_clk)
  begin
    if (reset || lane.coding_rst || !lane.link_active)
    begin
      lane.tx_char <= IDLE_CHAR;
      lane.tx_is_k <= 1'b0;
    end
    else if (!lane.link_run)
    begin
      lane.tx_char <= K_COMMA_CHAR;
      lane.tx_is_k <= 1'b1;
    end
    else if (!lane.direct_mode || !phase)
    begin
      lane.tx_char <= lane.user_char;
      lane.tx_is_k <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Serializer section
  // ----------------------------------------------------------------
  // serializer held
  always_ff @(posedge core_clk)
  begin
    if (reset || lane.serializer_rst)
      lane.serializer_on <= 1'b0;
    else
      lane.serializer_on <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Reset status back to the controller
  // ----------------------------------------------------------------
  // status report
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      lane.coding_rst_stat     <= 1'b1;
      lane.serializer_rst_stat <= 1'b1;
    end
    else
    begin
      lane.coding_rst_stat     <= lane.coding_rst;
      lane.serializer_rst_stat <= lane.serializer_rst;
    end
  end

endmodule // tx_lane_section

// [rtl/tx_clock_reset.sv]
/*
  Clock and reset front end of a multi-lane serial link transmitter:
  link reset synchronisation, per-lane reset inputs and status, per-lane
  parallel clock strobes and comma stream after link reset release.
  Assumes core_clk is the link clock and the per-lane resets come from an
  external reset controller on an unrelated clock.
*/

module tx_clock_reset
  import tx_clock_reset_pkg::*;
(
  input  wire logic                           core_clk,
  input  wire logic                           reset,
  input  wire logic                           link_rst_n,
  input  wire logic [MODE_W-1:0]              coding_mode,
  input  wire logic                           link_init_go,
  input  wire logic [NUM_LANES-1:0]           coding_rst,
  input  wire logic [NUM_LANES-1:0]           serializer_rst,
  input  wire logic [NUM_LANES*CHAR_W-1:0]    user_chars,
  output logic      [NUM_LANES-1:0]           par_clk_strobe,
  output logic      [NUM_LANES-1:0]           par_clk,
  output logic      [NUM_LANES*CHAR_W-1:0]    tx_chars,
  output logic      [NUM_LANES-1:0]           tx_is_k,
  output logic      [NUM_LANES-1:0]           serializer_on,
  output logic      [NUM_LANES-1:0]           coding_rst_stat,
  output logic      [NUM_LANES-1:0]           serializer_rst_stat,
  output logic                                link_in_reset,
  output logic                                link_sending_comma
);

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  function automatic logic mode_is_direct(input logic [MODE_W-1:0] mode);
    mode_is_direct = (mode == MODE_DIRECT);
  endfunction

  function automatic logic mode_is_coding(input logic [MODE_W-1:0] mode);
    mode_is_coding = (mode == MODE_HARD_CODING) || (mode == MODE_SOFT_CODING);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] link_rst_sync;
  logic              link_released;
  logic              direct_mode;
  link_state_t       state;
  link_state_t       next_state;
  logic [NUM_LANES-1:0] coding_rst_meta;
  logic [NUM_LANES-1:0] coding_rst_sync;
  logic [NUM_LANES-1:0] serializer_rst_meta;
  logic [NUM_LANES-1:0] serializer_rst_sync;

  lane_ctrl_if lanes [NUM_LANES] ();

  // ----------------------------------------------------------------
  // Link reset synchroniser
  // ----------------------------------------------------------------
  // active-low release sync
  always_ff @(posedge core_clk)
  begin
    if (reset)
      link_rst_sync <= SYNC_RESET;
    else
      link_rst_sync <= {link_rst_sync[0], link_rst_n};
  end

  assign link_released = link_rst_sync[SYNC_W-1];

  // ----------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------
  // Unknown encodings keep the previously selected mode timing
  always_ff @(posedge core_clk)
  begin
    if (reset)
      direct_mode <= 1'b0;
    else if (mode_is_direct(coding_mode))
      direct_mode <= 1'b1;
    else if (mode_is_coding(coding_mode))
      direct_mode <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Lane reset synchronisers
  // ----------------------------------------------------------------
  // synchronise per-lane resets; held asserted during reset
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      coding_rst_meta     <= '1;
      coding_rst_sync     <= '1;
      serializer_rst_meta <= '1;
      serializer_rst_sync <= '1;
    end
    else
    begin
      coding_rst_meta     <= coding_rst;
      coding_rst_sync     <= coding_rst_meta;
      serializer_rst_meta <= serializer_rst;
      serializer_rst_sync <= serializer_rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Link state machine
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      LINK_HELD:
      begin
        if (link_released)
          next_state = LINK_COMMA;
      end
      LINK_COMMA:
      begin
        if (!link_released)
          next_state = LINK_HELD;
        else if (link_init_go)
          next_state = LINK_RUN;
      end
      LINK_RUN:
      begin
        if (!link_released)
          next_state = LINK_HELD;
      end
      default:
        next_state = LINK_HELD;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      state <= LINK_HELD;
    else
      state <= next_state;
  end

  // ----------------------------------------------------------------
  // Link status outputs
  // ----------------------------------------------------------------
  // comma phase flag
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      link_in_reset      <= 1'b1;
      link_sending_comma <= 1'b0;
    end
    else
    begin
      link_in_reset      <= (next_state == LINK_HELD);
      link_sending_comma <= (next_state == LINK_COMMA);
    end
  end

  // ----------------------------------------------------------------
  // Lane sections
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_LANES; g = g + 1)
    begin : gen_lane
      assign lanes[g].coding_rst     = coding_rst_sync[g];
      assign lanes[g].serializer_rst = serializer_rst_sync[g];
      assign lanes[g].link_active    = (state != LINK_HELD);
      assign lanes[g].link_run       = (state == LINK_RUN);
      assign lanes[g].direct_mode    = direct_mode;
      assign lanes[g].user_char      = user_chars[g*CHAR_W +: CHAR_W];

      tx_lane_section u_lane (
        .core_clk (core_clk),
        .reset    (reset),
        .lane     (lanes[g])
      );

      assign par_clk_strobe[g]             = lanes[g].par_clk_strobe;
      assign par_clk[g]                    = lanes[g].par_clk;
      assign tx_chars[g*CHAR_W +: CHAR_W]  = lanes[g].tx_char;
      assign tx_is_k[g]                    = lanes[g].tx_is_k;
      assign serializer_on[g]              = lanes[g].serializer_on;
      assign coding_rst_stat[g]            = lanes[g].coding_rst_stat;
      assign serializer_rst_stat[g]        = lanes[g].serializer_rst_stat;
    end
  endgenerate

endmodule // tx_clock_reset

// [testbench/tx_clock_reset_chk.sv]
/* Port assertions for tx_clock_reset.
   Assumes binding onto the top module, one core_clk domain. */
module tx_clock_reset_chk
  import tx_clock_reset_pkg::*;
(
  input wire logic                        core_clk,
  input wire logic                        reset,
  input wire logic                        link_rst_n,
  input wire logic [MODE_W-1:0]           coding_mode,
  input wire logic                        link_init_go,
  input wire logic [NUM_LANES-1:0]        coding_rst,
  input wire logic [NUM_LANES-1:0]        serializer_rst,
  input wire logic [NUM_LANES-1:0]        par_clk_strobe,
  input wire logic [NUM_LANES-1:0]        par_clk,
  input wire logic [NUM_LANES*CHAR_W-1:0] tx_chars,
  input wire logic [NUM_LANES-1:0]        tx_is_k,
  input wire logic [NUM_LANES-1:0]        serializer_on,
  input wire logic [NUM_LANES-1:0]        coding_rst_stat,
  input wire logic [NUM_LANES-1:0]        serializer_rst_stat,
  input wire logic                        link_in_reset,
  input wire logic                        link_sending_comma
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Cycles since reset release
  // ------------------------------------------------------------
  logic [2:0] calm;
  logic       settled;
  always_ff @(posedge core_clk)
  begin
    if (reset)
      calm <= 3'h0;
    else if (calm != 3'h4)
      calm <= calm + 3'h1;
  end
  assign settled = (calm == 3'h4);

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence release_s;
    settled && $rose(link_rst_n) ##1 link_rst_n [*2];
  endsequence
  sequence stable_s(logic [MODE_W-1:0] m);
    settled && coding_rst_stat == '0 && $past(coding_rst_stat) == '0 && coding_mode == m
      && $past(coding_mode) == m && $past(coding_mode, 2) == m && $past(coding_mode, 3) == m;
  endsequence

  link_hold_a: assert property ((!link_rst_n) [*3] |=> link_in_reset && !link_sending_comma)
    else $error("link not held while reset low");
  comma_start_a: assert property (release_s |=> link_sending_comma && !link_in_reset)
    else $error("comma phase not entered three edges after release");
  comma_chars_a: assert property ($past(link_sending_comma) && coding_rst_stat == '0
    |-> tx_is_k == '1 && tx_chars == {NUM_LANES{K_COMMA_CHAR}})
    else $error("comma characters missing");
  init_run_a: assert property (link_sending_comma && link_init_go |-> ##[1:2] !link_sending_comma)
    else $error("comma phase did not end");
  coding_stat_a: assert property (settled |-> coding_rst_stat == $past(coding_rst, 3))
    else $error("coding status does not follow its reset");
  serial_stat_a: assert property (settled |-> serializer_rst_stat == $past(serializer_rst, 3))
    else $error("serializer status does not follow its reset");
  coding_hold_a: assert property ((par_clk & coding_rst_stat) == '0 && (tx_is_k & coding_rst_stat) == '0)
    else $error("lane active during coding reset");
  serial_hold_a: assert property ((serializer_on & serializer_rst_stat) == '0)
    else $error("serializer on during its reset");
  full_rate_a: assert property (stable_s(MODE_HARD_CODING) or stable_s(MODE_SOFT_CODING)
    |-> par_clk_strobe == '1 && par_clk == ~$past(par_clk))
    else $error("parallel clock not at link rate");
  half_rate_a: assert property (stable_s(MODE_DIRECT)
    |-> par_clk_strobe == ~$past(par_clk_strobe) && par_clk == ~$past(par_clk))
    else $error("parallel clock not at half rate");
endmodule // tx_clock_reset_chk

bind tx_clock_reset tx_clock_reset_chk chk (.core_clk(core_clk), .reset(reset),
  .link_rst_n(link_rst_n), .coding_mode(coding_mode), .link_init_go(link_init_go),
  .coding_rst(coding_rst), .serializer_rst(serializer_rst), .par_clk_strobe(par_clk_strobe),
  .par_clk(par_clk), .tx_chars(tx_chars), .tx_is_k(tx_is_k), .serializer_on(serializer_on),
  .coding_rst_stat(coding_rst_stat), .serializer_rst_stat(serializer_rst_stat),
  .link_in_reset(link_in_reset), .link_sending_comma(link_sending_comma));

// [testbench/rst_ctrl_model.sv]
/* Transceiver reset controller model.
   Assumes stats come back from tx_clock_reset on the same clock. */
module rst_ctrl_model
  import tx_clock_reset_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  input  wire logic [NUM_LANES-1:0] lane_hold,
  input  wire logic                 link_go,
  input  wire logic [NUM_LANES-1:0] coding_stat,
  input  wire logic [NUM_LANES-1:0] serial_stat,
  output logic      [NUM_LANES-1:0] coding_rst,
  output logic      [NUM_LANES-1:0] serializer_rst,
  output logic                      link_rst_n
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      coding_rst     <= '1;
      serializer_rst <= '1;
      link_rst_n     <= 1'b0;
    end
    else
    begin
      serializer_rst <= lane_hold;
      coding_rst     <= lane_hold | serial_stat;
      link_rst_n     <= link_go & (link_rst_n | ~|(coding_stat | serial_stat));
    end
  end
endmodule // rst_ctrl_model

// [testbench/tb.sv]
/* Self-checking bench for tx_clock_reset.
   Assumes the reset controller model drives all lane and link resets. */
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tx_clock_reset_pkg::*;
  logic                        core_clk, reset, link_go, link_init_go, link_rst_n;
  logic [MODE_W-1:0]           coding_mode;
  logic [NUM_LANES-1:0]        lane_hold, coding_rst, serializer_rst, par_clk_strobe, par_clk;
  logic [NUM_LANES-1:0]        tx_is_k, serializer_on, coding_rst_stat, serializer_rst_stat;
  logic [NUM_LANES*CHAR_W-1:0] user_chars, tx_chars;
  logic                        link_in_reset, link_sending_comma;
  int                          seed = 63, bad_count = 0, cmp_count = 0, cyc = 0, n, p;

  tx_clock_reset uut (.core_clk(core_clk), .reset(reset), .link_rst_n(link_rst_n),
    .coding_mode(coding_mode), .link_init_go(link_init_go), .coding_rst(coding_rst),
    .serializer_rst(serializer_rst), .user_chars(user_chars), .par_clk_strobe(par_clk_strobe),
    .par_clk(par_clk), .tx_chars(tx_chars), .tx_is_k(tx_is_k), .serializer_on(serializer_on),
    .coding_rst_stat(coding_rst_stat), .serializer_rst_stat(serializer_rst_stat),
    .link_in_reset(link_in_reset), .link_sending_comma(link_sending_comma));
  rst_ctrl_model ctrl (.core_clk(core_clk), .reset(reset), .lane_hold(lane_hold),
    .link_go(link_go), .coding_stat(coding_rst_stat), .serial_stat(serializer_rst_stat),
    .coding_rst(coding_rst), .serializer_rst(serializer_rst), .link_rst_n(link_rst_n));

  // link clock from core PLL, 10 ns
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  function automatic logic [NUM_LANES*CHAR_W-1:0] exp_lanes(input logic [NUM_LANES-1:0] m,
                                                           input logic [NUM_LANES*CHAR_W-1:0] c);
    for (int g = 0; g < NUM_LANES; g++)
      if (m[g])
        c[g*CHAR_W +: CHAR_W] = IDLE_CHAR;
    return c;
  endfunction

  task automatic report_and_stop;
    if (bad_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      report_and_stop;
    end
  end

  initial
  begin
    {reset, link_go, link_init_go, lane_hold, coding_mode, user_chars} = '1;
    {link_go, link_init_go, lane_hold, coding_mode} = '0;
    step(6);
    reset = 1'b0;
    step(2);
    `CHK(link_in_reset, 1'b1)
    link_go = 1'b1;
    for (int i = 0; i < 30 && link_sending_comma !== 1'b1; i++)
      step(1);
    step(1);
    `CHK(tx_is_k, {NUM_LANES{1'b1}})
    `CHK(tx_chars, {NUM_LANES{K_COMMA_CHAR}})
    for (int m = 0; m < 3; m++)
    begin
      coding_mode = m[MODE_W-1:0];
      step(4);
      n = 0;
      p = 0;
      repeat (8)
      begin
        n += $countones(par_clk_strobe);
        p += $countones(par_clk);
        step(1);
      end
      `CHK(n, 8 * NUM_LANES / ((coding_mode == MODE_DIRECT) ? DIRECT_CLK_DIVISOR : 1))
      `CHK(p, 4 * NUM_LANES)
    end
    coding_mode = MODE_HARD_CODING;
    link_init_go = 1'b1;
    step(1);
    link_init_go = 1'b0;
    step(3);
    `CHK(link_sending_comma, 1'b0)
    for (int i = 0; i < 14; i++)
    begin
      user_chars = $random(seed);
      lane_hold = (i == 0) ? '1 : (i == 1) ? '0 : 4'($random(seed));
      step(8);
      `CHK(coding_rst_stat, lane_hold)
      `CHK(serializer_rst_stat, lane_hold)
      `CHK(serializer_on, ~lane_hold)
      `CHK(tx_chars, exp_lanes(lane_hold, user_chars))
    end
    lane_hold = '0;
    link_go = 1'b0;
    step(5);
    `CHK(link_in_reset, 1'b1)
    link_go = 1'b1;
    for (int i = 0; i < 30 && link_rst_n !== 1'b1; i++)
      step(1);
    step(2);
    `CHK(link_sending_comma, 1'b0)
    step(1);
    `CHK(link_sending_comma, 1'b1)
    report_and_stop;
  end
endmodule // tb
